// ---- interrupt_vector_dispatch.sv ----
`timescale 1ns/10ps
module interrupt_vector_dispatch
   import dispatch_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_sys_i,
   input  wire logic                        resetn_i,
   // Instruction execution
   input  wire dispatch_pkg::instr_s        instr_i,
   input  wire dispatch_pkg::flags_s        flags_i,
   output logic                             stall_o,
   // Flag control
   output logic                             flags_save_o,
   output logic                             flags_restore_o,
   output logic                             flags_clear_o,
   // Control transfer
   output logic                             jump_o,
   output dispatch_pkg::vector_s            jump_vec_o,
   output logic [dispatch_pkg::TYPE_W-1:0]  jump_type_o,
   // External interrupt pins
   input  wire logic                        nmi_i,
   input  wire logic                        maskable_request_pin_i,
   output logic                             acknowledge_cycle_o,
   input  wire logic                        ack_data_valid_i,
   input  wire logic [15:0]                 ack_data_i,
   // Vector table memory
   output logic                             mem_rd_o,
   output logic [dispatch_pkg::ADDR_W-1:0]  mem_addr_o,
   input  wire logic                        mem_ack_i,
   input  wire logic [15:0]                 mem_data_i
);

   // ****************************************
   // Declarations
   // ****************************************
   typedef enum logic [2:0] {
      S_RUN, S_ACK1, S_ACK_IDLE, S_ACK2, S_FETCH, S_JUMP
   } disp_e;

   disp_e              state_r;
   logic [2:0]         nmi_sync_r;
   logic               nmi_pend_r;
   logic               step_arm_r;
   logic [1:0]         idle_cnt_r;
   logic [TYPE_W-1:0]  type_r;
   logic               fetch_start;
   logic               fetch_busy;
   logic               fetch_done;
   vector_s            fetch_vec;
   logic               boundary;
   logic               sw_hit;
   logic [TYPE_W-1:0]  sw_type;
   logic               step_hit;
   logic               maskable_request_pin_hit;
   logic               nmi_service;

   // ****************************************
   // Non-maskable input
   // ****************************************
   // Rise counts only once second and third stages agree
   logic nmi_level_r;
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         nmi_sync_r  <= '0;
         nmi_level_r <= 1'b0;
      end else begin
         nmi_sync_r <= {nmi_sync_r[1:0], nmi_i};
         if (nmi_sync_r[1] == nmi_sync_r[2]) begin
            nmi_level_r <= nmi_sync_r[2];
         end
      end
   end

   wire nmi_edge = (nmi_sync_r[1] == nmi_sync_r[2]) & nmi_sync_r[2] & ~nmi_level_r;

   // Latched so a short pulse is still serviced; set wins over clear
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         nmi_pend_r <= 1'b0;
      end else if (nmi_edge) begin
         nmi_pend_r <= 1'b1;
      end else if (nmi_service) begin
         nmi_pend_r <= 1'b0;
      end
   end

   // ****************************************
   // Source selection
   // ****************************************
   assign boundary = instr_i.valid & instr_i.last_clk & (state_r == S_RUN);

   always_comb begin
      sw_hit  = 1'b0;
      sw_type = TYPE_DIVIDE;
      if (instr_i.valid && instr_i.div_overflow) begin
         sw_hit  = 1'b1;
         sw_type = TYPE_DIVIDE;
      end else if (instr_i.opcode == OP_SOFT_TRAP) begin
         sw_hit  = 1'b1;
         sw_type = instr_i.operand;
      end else if (instr_i.opcode == OP_BREAK) begin
         sw_hit  = 1'b1;
         sw_type = TYPE_BREAK;
      end else if (instr_i.opcode == OP_OVF_TRAP && flags_i.overflow_flag) begin
         sw_hit  = 1'b1;
         sw_type = TYPE_OVERFLOW;
      end
   end

   // Step ignores interrupt enable
   assign step_hit    = step_arm_r;
   // Kept pending while a step trap wins the boundary, so the edge is not lost
   assign nmi_service = boundary & ~sw_hit & ~step_hit & nmi_pend_r;
   assign maskable_request_pin_hit    = maskable_request_pin_i & flags_i.int_enable;

   // Armed at the boundary after the flag was already set, so one
   // instruction runs first; a trap return arms only after the next one
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         step_arm_r <= 1'b0;
      end else if (boundary) begin
         step_arm_r <= flags_i.trap_flag && (instr_i.opcode != OP_TRAP_RET)
                       && !sw_hit && !step_arm_r;
      end
   end

   // ****************************************
   // Dispatch sequence
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r    <= S_RUN;
         type_r     <= '0;
         idle_cnt_r <= '0;
      end else begin
         case (state_r)
            S_RUN: begin
               if (boundary) begin
                  if (sw_hit) begin
                     type_r  <= sw_type;
                     state_r <= S_FETCH;
                  end else if (step_hit) begin
                     type_r  <= TYPE_STEP;
                     state_r <= S_FETCH;
                  end else if (nmi_pend_r) begin
                     type_r  <= TYPE_NMI;
                     state_r <= S_FETCH;
                  end else if (maskable_request_pin_hit) begin
                     state_r <= S_ACK1;
                  end
               end
            end
            S_ACK1: begin
               idle_cnt_r <= '0;
               state_r    <= S_ACK_IDLE;
            end
            S_ACK_IDLE: begin
               idle_cnt_r <= idle_cnt_r + 2'h1;
               if (idle_cnt_r == ACK_IDLE_LAST) begin
                  state_r <= S_ACK2;
               end
            end
            S_ACK2: begin
               if (ack_data_valid_i) begin
                  type_r  <= ack_data_i[7:0];
                  state_r <= S_FETCH;
               end
            end
            S_FETCH: begin
               if (fetch_done) begin
                  state_r <= S_JUMP;
               end
            end
            S_JUMP:  state_r <= S_RUN;
            default: state_r <= S_RUN;
         endcase
      end
   end

   assign fetch_start = (state_r == S_FETCH) & ~fetch_busy & ~fetch_done;

   vector_fetch u_fetch (
      .clk_sys_i  (clk_sys_i),
      .resetn_i   (resetn_i),
      .start_i    (fetch_start),
      .type_i     (type_r),
      .busy_o     (fetch_busy),
      .done_o     (fetch_done),
      .vector_o   (fetch_vec),
      .mem_rd_o   (mem_rd_o),
      .mem_addr_o (mem_addr_o),
      .mem_ack_i  (mem_ack_i),
      .mem_data_i (mem_data_i)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign acknowledge_cycle_o = (state_r == S_ACK1) | (state_r == S_ACK2);
   assign stall_o             = (state_r != S_RUN);
   assign flags_restore_o     = boundary & (instr_i.opcode == OP_TRAP_RET) & ~sw_hit;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         jump_o       <= 1'b0;
         jump_vec_o   <= '0;
         jump_type_o  <= '0;
         flags_save_o <= 1'b0;
         flags_clear_o <= 1'b0;
      end else begin
         jump_o        <= (state_r == S_FETCH) & fetch_done;
         flags_save_o  <= (state_r == S_FETCH) & fetch_done;
         flags_clear_o <= (state_r == S_FETCH) & fetch_done;
         if ((state_r == S_FETCH) && fetch_done) begin
            jump_vec_o  <= fetch_vec;
            jump_type_o <= type_r;
         end
      end
   end

endmodule // interrupt_vector_dispatch

// ---- dispatch_pkg.sv ----
package dispatch_pkg;

   // ****************************************
   // Vector table layout
   // ****************************************
   localparam logic [19:0] VEC_TABLE_BASE = 20'h0_0000;
   localparam logic [19:0] VEC_TABLE_LAST = 20'h0_03FF;
   localparam int          VEC_BYTES      = 4;
   localparam int          TYPE_W         = 8;
   localparam int          ADDR_W         = 20;

   // ****************************************
   // Predefined types
   // ****************************************
   localparam logic [7:0] TYPE_DIVIDE   = 8'h00;
   localparam logic [7:0] TYPE_STEP     = 8'h01;
   localparam logic [7:0] TYPE_NMI      = 8'h02;
   localparam logic [7:0] TYPE_BREAK    = 8'h03;
   localparam logic [7:0] TYPE_OVERFLOW = 8'h04;

   // ****************************************
   // Opcodes and timing
   // ****************************************
   localparam logic [7:0] OP_SOFT_TRAP  = 8'hCD;
   localparam logic [7:0] OP_BREAK     = 8'hCC;
   localparam logic [7:0] OP_OVF_TRAP  = 8'hCE;
   localparam logic [7:0] OP_TRAP_RET  = 8'hCF;
   localparam int         ACK_IDLE_CLKS = 2;
   localparam logic [1:0] ACK_IDLE_LAST = 2'h1;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
      logic [7:0] operand;
      logic       last_clk;
      logic       div_overflow;
   } instr_s;

   typedef struct packed {
      logic        trap_flag;
      logic        overflow_flag;
      logic        int_enable;
   } flags_s;

   typedef struct packed {
      logic [15:0] ip;
      logic [15:0] cs;
   } vector_s;

endpackage

// ---- vector_fetch.sv ----
`timescale 1ns/10ps
module vector_fetch
   import dispatch_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk_sys_i,
   input  wire logic                        resetn_i,
   // Request
   input  wire logic                        start_i,
   input  wire logic [dispatch_pkg::TYPE_W-1:0] type_i,
   output logic                             busy_o,
   output logic                             done_o,
   output dispatch_pkg::vector_s            vector_o,
   // Memory word port
   output logic                             mem_rd_o,
   output logic [dispatch_pkg::ADDR_W-1:0]  mem_addr_o,
   input  wire logic                        mem_ack_i,
   input  wire logic [15:0]                 mem_data_i
);

   typedef enum logic [1:0] {F_IDLE, F_IP, F_CS} fetch_e;

   fetch_e                     state_r;
   logic [ADDR_W-1:0]          base_r;

   // Type times four, inside the table
   function automatic logic [ADDR_W-1:0] vec_addr(input logic [TYPE_W-1:0] t);
      vec_addr = VEC_TABLE_BASE | {10'h000, t, 2'b00};
   endfunction

   assign busy_o     = (state_r != F_IDLE);
   assign mem_rd_o   = busy_o;
   assign mem_addr_o = (state_r == F_CS) ? base_r + 20'h0_0002 : base_r;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r  <= F_IDLE;
         base_r   <= '0;
         vector_o <= '0;
         done_o   <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (state_r)
            F_IDLE: begin
               if (start_i) begin
                  base_r  <= vec_addr(type_i);
                  state_r <= F_IP;
               end
            end
            F_IP: begin
               if (mem_ack_i) begin
                  vector_o.ip <= mem_data_i;
                  state_r     <= F_CS;
               end
            end
            F_CS: begin
               if (mem_ack_i) begin
                  vector_o.cs <= mem_data_i;
                  done_o      <= 1'b1;
                  state_r     <= F_IDLE;
               end
            end
            default: state_r <= F_IDLE;
         endcase
      end
   end

endmodule // vector_fetch

// ---- interrupt_vector_dispatch_assertions.sv ----
`timescale 1ns/10ps
// ****************************************
// Dispatch checker
// ****************************************
module ivd_checker (
   // Watched ports
   input wire logic                                 clk_sys_i,
   input wire logic                                 resetn_i,
   input wire dispatch_pkg::instr_s                 instr_i,
   input wire dispatch_pkg::flags_s                 flags_i,
   input wire logic                                 stall_o,
   input wire logic                                 flags_save_o,
   input wire logic                                 flags_clear_o,
   input wire logic                                 jump_o,
   input wire logic [dispatch_pkg::TYPE_W-1:0]      jump_type_o,
   input wire logic                                 acknowledge_cycle_o,
   input wire logic                                 mem_rd_o,
   input wire logic [dispatch_pkg::ADDR_W-1:0]      mem_addr_o,
   input wire logic                                 mem_ack_i
);
   import dispatch_pkg::*;
   logic [19:0] ip_addr_r;
   logic        second_r;
   logic        ack_q_r;
   // Ip word address kept to judge the cs word and the type
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ip_addr_r <= 20'h0_0000;
         second_r  <= 1'b0;
         ack_q_r   <= 1'b0;
      end else begin
         ack_q_r <= acknowledge_cycle_o;
         if (mem_rd_o && mem_ack_i && !mem_addr_o[1]) begin
            ip_addr_r <= mem_addr_o;
         end
         if (ack_q_r && !acknowledge_cycle_o) begin
            second_r <= !second_r;
         end
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   sequence s_taken(op);
      instr_i.valid && instr_i.last_clk && !stall_o && !instr_i.div_overflow
         && instr_i.opcode == op;
   endsequence
   sequence s_ack_gap;
      !acknowledge_cycle_o ##1 !acknowledge_cycle_o ##1 acknowledge_cycle_o;
   endsequence
   AST_TABLE_RANGE: assert property (mem_rd_o |-> mem_addr_o[19:10] == 10'h000
      && !mem_addr_o[0]) else $error("vector read outside table");
   AST_CS_WORD: assert property ((mem_rd_o && mem_ack_i && !mem_addr_o[1]) |=>
      ##[0:2] (mem_rd_o && mem_addr_o == ip_addr_r + 20'h0_0002))
      else $error("cs word not at ip plus two");
   AST_JUMP_AFTER_CS: assert property ((mem_rd_o && mem_ack_i && mem_addr_o[1]) |->
      ##[1:2] jump_o) else $error("no jump after cs word");
   AST_JUMP_TYPE: assert property (jump_o |-> jump_type_o == ip_addr_r[9:2])
      else $error("jump type does not match vector offset");
   AST_SAVE_CLEAR: assert property ((jump_o || flags_save_o || flags_clear_o) |->
      (jump_o && flags_save_o && flags_clear_o)) else $error("save or clear apart from jump");
   AST_SOFT_ADDR: assert property (s_taken(OP_SOFT_TRAP) |=> ##1 mem_rd_o
      && mem_addr_o == {10'h000, $past(instr_i.operand, 2), 2'h0})
      else $error("soft trap vector address wrong");
   AST_BREAK_ADDR: assert property (s_taken(OP_BREAK) |=> ##1 mem_rd_o
      && mem_addr_o == 20'h0_000C) else $error("breakpoint vector address wrong");
   AST_OVF_ADDR: assert property (s_taken(OP_OVF_TRAP) ##0 flags_i.overflow_flag |=>
      ##1 mem_rd_o && mem_addr_o == 20'h0_0010) else $error("overflow vector address wrong");
   AST_DIV_ADDR: assert property ((instr_i.valid && instr_i.last_clk && instr_i.div_overflow
      && !stall_o) |=> ##1 mem_rd_o && mem_addr_o == 20'h0_0000)
      else $error("divide error vector address wrong");
   AST_MASK_REFUSED: assert property ((instr_i.valid && instr_i.last_clk && !stall_o
      && !flags_i.int_enable) |=> !acknowledge_cycle_o) else $error("acknowledge while disabled");
   AST_ACK_GAP: assert property ((acknowledge_cycle_o && !ack_q_r && !second_r) |=>
      s_ack_gap) else $error("acknowledge spacing wrong");
endmodule // ivd_checker
bind interrupt_vector_dispatch ivd_checker ivd_checker_i (.clk_sys_i, .resetn_i, .instr_i,
   .flags_i, .stall_o, .flags_save_o, .flags_clear_o, .jump_o, .jump_type_o,
   .acknowledge_cycle_o, .mem_rd_o, .mem_addr_o, .mem_ack_i);

// ---- ivd_far_side.sv ----
`timescale 1ns/10ps
// ****************************************
// Vector memory and acknowledge source
// ****************************************
module ivd_far_side #(
   parameter logic [7:0] ACK_TYPE = 8'h41
) (
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   input  wire logic        slow_i,
   input  wire logic        mem_rd_i,
   input  wire logic [19:0] mem_addr_i,
   output logic             mem_ack_o,
   output logic [15:0]      mem_data_o,
   input  wire logic        ack_cycle_i,
   output logic             ack_valid_o,
   output logic [15:0]      ack_data_o
);
   logic [1:0]  wait_r;
   logic [15:0] word_r;
   logic        got_first_r;
   logic        ack_q_r;
   // Off-cycle data inverted so a stale word never passes
   assign mem_data_o = mem_ack_o ? word_r : ~word_r;
   assign ack_data_o = ack_valid_o ? {8'hE7, ACK_TYPE} : ~{8'hE7, ACK_TYPE};
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mem_ack_o <= 1'b0;
         wait_r    <= 2'h0;
         word_r    <= 16'h0000;
      end else if (mem_ack_o) begin
         mem_ack_o <= 1'b0;
         wait_r    <= 2'h0;
      end else if (mem_rd_i && (wait_r == 2'h3 || !slow_i)) begin
         mem_ack_o <= 1'b1;
         word_r    <= mem_addr_i[15:0] ^ 16'hA5C3;
      end else if (mem_rd_i) begin
         wait_r <= wait_r + 2'h1;
      end
   end
   // Type only on the second acknowledge
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_valid_o <= 1'b0;
         got_first_r <= 1'b0;
         ack_q_r     <= 1'b0;
      end else begin
         ack_q_r <= ack_cycle_i;
         if (ack_valid_o) begin
            ack_valid_o <= 1'b0;
            got_first_r <= 1'b0;
         end else if (ack_cycle_i && !ack_q_r) begin
            ack_valid_o <= got_first_r;
            got_first_r <= 1'b1;
         end
      end
   end
endmodule // ivd_far_side

// ---- interrupt_vector_dispatch_tb_top.sv ----
`timescale 1ns/10ps
module interrupt_vector_dispatch_tb_top;
   import dispatch_pkg::*;
   typedef struct {
      instr_s     ins;
      flags_s     fl;
      logic       pin;
      logic       exp;
      logic [7:0] typ;
   } row_s;
   logic        clk_sys_i, resetn_i, nmi_i, maskable_request_pin_i, slow;
   instr_s      instr_i;
   flags_s      flags_i;
   logic        stall_o, flags_save_o, flags_restore_o, flags_clear_o, jump_o;
   vector_s     jump_vec_o;
   logic [7:0]  jump_type_o;
   logic        acknowledge_cycle_o, ack_data_valid_i, mem_rd_o, mem_ack_i;
   logic [15:0] ack_data_i, mem_data_i;
   logic [19:0] mem_addr_o;
   logic        got, rest;
   logic [41:0] seen;
   row_s        rows [9];
   int          bad_count, n_checks, i;
   interrupt_vector_dispatch interrupt_vector_dispatch_i (.clk_sys_i, .resetn_i, .instr_i,
      .flags_i, .stall_o, .flags_save_o, .flags_restore_o, .flags_clear_o, .jump_o,
      .jump_vec_o, .jump_type_o, .nmi_i, .maskable_request_pin_i, .acknowledge_cycle_o,
      .ack_data_valid_i, .ack_data_i, .mem_rd_o, .mem_addr_o, .mem_ack_i, .mem_data_i);
   ivd_far_side #(.ACK_TYPE(8'h41)) ivd_far_side_i (.clk_sys_i, .resetn_i, .slow_i(slow),
      .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
      .mem_data_o(mem_data_i), .ack_cycle_i(acknowledge_cycle_o),
      .ack_valid_o(ack_data_valid_i), .ack_data_o(ack_data_i));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic instr_s mk(input logic [7:0] op, od, input logic dv);
      return '{1'b1, op, od, 1'b1, dv};
   endfunction
   function automatic logic [15:0] fw(input logic [9:0] a);
      return {6'h00, a} ^ 16'hA5C3;
   endfunction
   task automatic chk(input logic [41:0] s, e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic run(input instr_s ins, input flags_s fl, input logic p);
      int k;
      @(posedge clk_sys_i);
      instr_i <= ins;
      flags_i <= fl;
      maskable_request_pin_i <= p;
      #1 rest = flags_restore_o;
      @(posedge clk_sys_i);
      instr_i <= '0;
      got = 1'b0;
      for (k = 0; k < 40 && !got; k++) begin
         @(posedge clk_sys_i);
         #1 got = (jump_o === 1'b1);
      end
      seen = {jump_type_o, jump_vec_o, flags_save_o, flags_clear_o};
   endtask
   task automatic chk_vec(input logic [7:0] t);
      chk(seen, {t, fw({t, 2'h0}), fw({t, 2'h2}), 2'h3});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // Clock, watchdog, sequence
   // ****************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #20000;
      bad_count++;
      tally_and_finish;
   end
   initial begin
      {resetn_i, nmi_i, maskable_request_pin_i, slow} = 4'h0;
      instr_i = '0;
      flags_i = '0;
      bad_count = 0;
      n_checks = 0;
      rows[0] = '{mk(OP_SOFT_TRAP, 8'h25, 1'b0), 3'b000, 1'b0, 1'b1, 8'h25};
      rows[1] = '{mk(OP_SOFT_TRAP, 8'hFF, 1'b0), 3'b001, 1'b0, 1'b1, 8'hFF};
      rows[2] = '{mk(OP_SOFT_TRAP, 8'h02, 1'b0), 3'b000, 1'b0, 1'b1, 8'h02};
      rows[3] = '{mk(OP_BREAK, 8'h00, 1'b0), 3'b000, 1'b0, 1'b1, 8'h03};
      rows[4] = '{mk(OP_OVF_TRAP, 8'h00, 1'b0), 3'b010, 1'b0, 1'b1, 8'h04};
      rows[5] = '{mk(OP_OVF_TRAP, 8'h00, 1'b0), 3'b000, 1'b0, 1'b0, 8'h00};
      rows[6] = '{mk(8'hF7, 8'h00, 1'b1), 3'b000, 1'b0, 1'b1, 8'h00};
      rows[7] = '{mk(8'h90, 8'h00, 1'b0), 3'b000, 1'b1, 1'b0, 8'h00};
      rows[8] = '{mk(8'h90, 8'h00, 1'b0), 3'b001, 1'b1, 1'b1, 8'h41};
      repeat (3) @(posedge clk_sys_i);
      #1 chk({jump_o, stall_o, mem_rd_o, acknowledge_cycle_o, flags_save_o}, 42'h0);
      @(posedge clk_sys_i) resetn_i <= 1'b1;
      for (i = 0; i < 9; i++) begin
         slow = i[0];
         run(rows[i].ins, rows[i].fl, rows[i].pin);
         chk(got, rows[i].exp);
         if (rows[i].exp) chk_vec(rows[i].typ);
      end
      // Trap return then one free instruction before the step trap
      run(mk(OP_TRAP_RET, 8'h00, 1'b0), 3'b100, 1'b0);
      chk({rest, got}, 42'h2);
      run(mk(8'h90, 8'h00, 1'b0), 3'b100, 1'b0);
      chk(got, 42'h0);
      run(mk(8'h90, 8'h00, 1'b0), 3'b000, 1'b0);
      chk(got, 42'h1);
      chk_vec(TYPE_STEP);
      // Short edge, gone before service, beside a maskable request
      @(posedge clk_sys_i) nmi_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      nmi_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      run(mk(8'h90, 8'h00, 1'b0), 3'b001, 1'b1);
      chk(got, 42'h1);
      chk_vec(TYPE_NMI);
      run(mk(8'h90, 8'h00, 1'b0), 3'b001, 1'b1);
      chk_vec(8'h41);
      tally_and_finish;
   end
endmodule // interrupt_vector_dispatch_tb_top
